// file: two_wire_pkg.sv
// shared constants and state types for the two-wire control port
package two_wire_pkg;

  // clock of both ends
  localparam int CLK_PERIOD_NS = 10;
  // serial clock period made by the host end, in ns
  localparam int SCL_PERIOD_NS = 2500;
  // quarter of a serial bit in system clocks, rounded down
  localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;

  // slave address with the select bit at zero (0x1C or 0x1D)
  localparam logic [6:0] ADDR_BASE = 7'h1C;
  // bits per byte, ninth clock is the acknowledge
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // reset value of every control register
  localparam logic [15:0] REG_DEFAULT = 16'h0000;
  // number of registers implemented in the device end
  localparam int REG_COUNT_DEF = 64;

  // write-side byte slots after the address byte
  localparam logic [1:0] SLOT_IDX_HI = 2'h0;
  localparam logic [1:0] SLOT_IDX_LO = 2'h1;
  localparam logic [1:0] SLOT_DAT_HI = 2'h2;
  localparam logic [1:0] SLOT_DAT_LO = 2'h3;

  // device end states
  typedef enum logic [7:0] {
    D_IDLE = 8'h01,
    D_ADDR = 8'h02,
    D_RX   = 8'h04,
    D_ACK  = 8'h08,
    D_TX   = 8'h10,
    D_RACK = 8'h20,
    D_RGO  = 8'h40,
    D_SKIP = 8'h80
  } dev_state_t;

  // host end states
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } host_state_t;

endpackage

// file: two_wire_if.sv
// open-drain two-wire bus joining host end and device end
`timescale 1ns/1ps
interface two_wire_if;
  logic host_scl_o;   // host clock drive value
  logic host_scl_oe;  // host pulls clock
  logic host_sda_o;   // host data drive value
  logic host_sda_oe;  // host pulls data
  logic dev_sda_o;    // device data drive value
  logic dev_sda_oe;   // device pulls data
  logic scl;          // resolved clock wire
  logic sda;          // resolved data wire

  // pull-ups: a wire is high unless an enabled driver drives it
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
               (dev_sda_oe ? dev_sda_o : 1'b1);

  // the device only listens to the clock, never drives it
  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

// file: two_wire_control_slave.sv
// device end: two-wire slave giving access to 16-bit control registers
`timescale 1ns/1ps
module two_wire_control_slave
  import two_wire_pkg::*;
#(
  parameter int NUM_REGS = REG_COUNT_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  two_wire_if.device       bus,
  input  wire logic        addr_sel,
  input  wire logic        soft_reset,
  output logic             wr_strobe_q,
  output logic [15:0]      wr_index_q,
  output logic [15:0]      wr_data_q
);

  localparam int IW = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  // refuse register counts the index cannot serve
  if (NUM_REGS < 2 || NUM_REGS > 65536) begin : g_check
    $error("NUM_REGS must lie between 2 and 65536");
  end

  logic             scl_m;       // first sync stage, clock
  logic             scl_r;       // second sync stage, clock
  logic             scl_p;       // previous synced clock
  logic             sda_m;       // first sync stage, data
  logic             sda_r;       // second sync stage, data
  logic             sda_p;       // previous synced data
  logic             sel_m;       // first sync stage, select pin
  logic             sel_r;       // second sync stage, select pin
  dev_state_t       state_q;     // bus-facing state
  logic [3:0]       bit_q;       // bit count within a byte
  logic [7:0]       shift_q;     // received byte
  logic             rd_mode_q;   // current address asked for a read
  logic             sda_oe_q;    // pull data low
  logic [7:0]       tx_q;        // byte being sent
  logic             tx_lo_q;     // low byte is in tx_q
  logic [1:0]       slot_q;      // write-side byte slot
  logic [15:0]      index_q;     // register index
  logic [7:0]       dat_hi_q;    // held high data byte
  logic [15:0]      regs_q [NUM_REGS];  // control registers
  logic             scl_rise;    // clock rising edge seen
  logic             scl_fall;    // clock falling edge seen
  logic             start_seen;  // start or repeated start
  logic             stop_seen;   // stop condition
  logic [6:0]       own_addr;    // slave address from strap
  logic             byte_end;    // eighth bit over, clock fell
  logic             addr_hit;    // address byte matched
  logic             rx_done;     // write-side byte complete
  logic             ack_rise;    // master acknowledged read byte
  logic             tx_shift;    // move to next transmit bit

  // one byte of a register; unimplemented indexes read as zero
  function automatic logic [7:0] read_byte(input logic [15:0] idx,
                                           input logic        hi);
    logic [15:0] w;
    w = (32'(idx) < NUM_REGS) ? regs_q[idx[IW-1:0]] : 16'h0000;
    read_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // synchronise pins; timing is all from sampled edges, so no
  // lower limit on the serial clock rate exists
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m <= 1'b1;
      scl_r <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_r <= 1'b1;
      sda_p <= 1'b1;
      sel_m <= 1'b0;
      sel_r <= 1'b0;
    end else begin
      scl_m <= bus.scl;
      scl_r <= scl_m;
      scl_p <= scl_r;
      sda_m <= bus.sda;
      sda_r <= sda_m;
      sda_p <= sda_r;
      sel_m <= addr_sel;
      sel_r <= sel_m;
    end
  end

  // edge and condition detection on synced copies only
  assign scl_rise   = scl_r & ~scl_p;
  assign scl_fall   = ~scl_r & scl_p;
  assign start_seen = scl_r & scl_p & sda_p & ~sda_r;
  assign stop_seen  = scl_r & scl_p & ~sda_p & sda_r;
  assign own_addr   = {ADDR_BASE[6:1], sel_r};
  assign byte_end   = scl_fall & (bit_q == BYTE_BITS);
  assign addr_hit   = (state_q == D_ADDR) & byte_end &
                      (shift_q[7:1] == own_addr);
  assign rx_done    = (state_q == D_RX) & byte_end;
  assign ack_rise   = (state_q == D_RACK) & scl_rise & ~sda_r;
  assign tx_shift   = (state_q == D_TX) & scl_fall & (bit_q != 4'h7);

  // the device never drives the clock and only drives data low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;

  // bus state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= D_IDLE;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      rd_mode_q <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (soft_reset) begin
      // whole port back to standby
      state_q   <= D_IDLE;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      rd_mode_q <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_seen) begin
      // a start anywhere restarts the address phase
      state_q  <= D_ADDR;
      bit_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_seen) begin
      state_q  <= D_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        D_ADDR, D_RX: begin
          if (scl_rise && bit_q != BYTE_BITS) begin
            // msb arrives first; direction bit is the last
            shift_q <= {shift_q[6:0], sda_r};
            bit_q   <= bit_q + 4'h1;
          end else if (byte_end) begin
            if (state_q == D_RX || addr_hit) begin
              sda_oe_q <= 1'b1;
              state_q  <= D_ACK;
            end else begin
              state_q <= D_SKIP;
            end
            if (state_q == D_ADDR) begin
              rd_mode_q <= shift_q[0];
            end
          end
        end
        D_ACK: begin
          // ninth clock over: release, or put first read bit out
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (rd_mode_q) begin
              state_q  <= D_TX;
              sda_oe_q <= ~tx_q[7];
            end else begin
              state_q  <= D_RX;
              sda_oe_q <= 1'b0;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              // let the master drive its acknowledge
              sda_oe_q <= 1'b0;
              state_q  <= D_RACK;
            end else begin
              sda_oe_q <= ~tx_q[6];
            end
          end
        end
        D_RACK: begin
          // a high level here means the master wants no more
          if (scl_rise) begin
            state_q <= sda_r ? D_SKIP : D_RGO;
          end
        end
        D_RGO: begin
          // keep sending until the master leaves a byte unacknowledged
          if (scl_fall) begin
            state_q  <= D_TX;
            bit_q    <= 4'h0;
            sda_oe_q <= ~tx_q[7];
          end
        end
        D_SKIP: begin
          // released; only a start, a stop or soft_reset leaves this state
          sda_oe_q <= 1'b0;
        end
        D_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q  <= D_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // index, write assembly and transmit byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_q      <= SLOT_IDX_HI;
      index_q     <= 16'h0000;
      dat_hi_q    <= 8'h00;
      tx_q        <= 8'h00;
      tx_lo_q     <= 1'b0;
      wr_strobe_q <= 1'b0;
      wr_index_q  <= 16'h0000;
      wr_data_q   <= 16'h0000;
    end else if (soft_reset) begin
      slot_q      <= SLOT_IDX_HI;
      index_q     <= 16'h0000;
      dat_hi_q    <= 8'h00;
      tx_q        <= 8'h00;
      tx_lo_q     <= 1'b0;
      wr_strobe_q <= 1'b0;
      wr_index_q  <= 16'h0000;
      wr_data_q   <= 16'h0000;
    end else begin
      wr_strobe_q <= 1'b0;
      if (addr_hit) begin
        slot_q <= SLOT_IDX_HI;
        if (shift_q[0]) begin
          // high byte of the selected register goes first
          tx_q    <= read_byte(index_q, 1'b1);
          tx_lo_q <= 1'b0;
        end
      end
      if (rx_done) begin
        case (slot_q)
          SLOT_IDX_HI: index_q[15:8] <= shift_q;
          SLOT_IDX_LO: index_q[7:0]  <= shift_q;
          SLOT_DAT_HI: dat_hi_q      <= shift_q;
          SLOT_DAT_LO: begin
            // word complete: write, then move to next register
            wr_strobe_q <= 1'b1;
            wr_index_q  <= index_q;
            wr_data_q   <= {dat_hi_q, shift_q};
            index_q     <= index_q + 16'h0001;
          end
          default: index_q <= index_q;
        endcase
        slot_q <= (slot_q == SLOT_DAT_LO) ? SLOT_DAT_HI : slot_q + 2'h1;
      end
      if (ack_rise) begin
        if (!tx_lo_q) begin
          tx_q    <= read_byte(index_q, 1'b0);
          tx_lo_q <= 1'b1;
        end else begin
          // 16-bit add rolls 0xFFFF over to 0x0000
          index_q <= index_q + 16'h0001;
          tx_q    <= read_byte(index_q + 16'h0001, 1'b1);
          tx_lo_q <= 1'b0;
        end
      end else if (tx_shift) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // register array; writes outside the array are dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_DEFAULT;
      end
    end else if (soft_reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_DEFAULT;
      end
    end else if (rx_done && slot_q == SLOT_DAT_LO &&
                 32'(index_q) < NUM_REGS) begin
      regs_q[index_q[IW-1:0]] <= {dat_hi_q, shift_q};
    end
  end

endmodule

// file: two_wire_host.sv
// host end: two-wire bus master issuing register writes and reads
`timescale 1ns/1ps
module two_wire_host
  import two_wire_pkg::*;
#(
  parameter int QTR_CYCLES = SCL_QTR_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  two_wire_if.host         bus,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_read,
  input  wire logic [6:0]  cmd_dev_addr,
  input  wire logic [15:0] cmd_index,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic [7:0]  cmd_words,
  output logic             cmd_ready_q,
  output logic             rd_valid_q,
  output logic [15:0]      rd_data_q,
  output logic             done_q,
  output logic             nack_q
);

  // edges of the device need a few clocks to be seen
  if (QTR_CYCLES < 4 || QTR_CYCLES > 4096) begin : g_check
    $error("QTR_CYCLES must lie between 4 and 4096");
  end

  host_state_t  state_q;    // bus operation in progress
  logic [12:0]  div_q;      // quarter-bit divider
  logic         tick;       // one-cycle quarter enable
  logic [1:0]   ph_q;       // quarter within a bit or condition
  logic [3:0]   bit_q;      // bit within a byte, 8 is ack
  logic [2:0]   step_q;     // byte position in the transfer
  logic         rd_q;       // transfer is a read
  logic         rxm_q;      // current byte comes from device
  logic         lo_q;       // next received byte is low byte
  logic [7:0]   words_q;    // read words still wanted
  logic [7:0]   tx_q;       // byte being sent
  logic [7:0]   rx_q;       // byte being received
  logic [7:0]   hi_q;       // held high read byte
  logic         ack_q;      // sampled acknowledge level
  logic [6:0]   dev_q;      // latched device address
  logic [15:0]  idx_q;      // latched index
  logic [15:0]  wd_q;       // latched write data
  logic         scl_q;      // 1 releases clock
  logic         sda_q;      // 1 releases data
  logic         sda_m;      // first sync stage
  logic         sda_r;      // second sync stage
  logic         last_rx;    // byte now received ends the read

  // byte sent at a given step
  function automatic logic [7:0] pick(input logic [2:0] s);
    case (s)
      3'h1:    pick = {dev_q, 1'b0};
      3'h2:    pick = idx_q[15:8];
      3'h3:    pick = idx_q[7:0];
      3'h4:    pick = wd_q[15:8];
      3'h5:    pick = rd_q ? {dev_q, 1'b1} : wd_q[7:0];
      default: pick = 8'h00;
    endcase
  endfunction

  assign tick    = (32'(div_q) == QTR_CYCLES - 1);
  assign last_rx = lo_q & (words_q == 8'h01);

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = ~scl_q;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = ~sda_q;

  // quarter-bit divider, runs only while busy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 13'h0000;
    end else if (state_q == H_IDLE || tick) begin
      div_q <= 13'h0000;
    end else begin
      div_q <= div_q + 13'h0001;
    end
  end

  // data wire comes from outside; two stages before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_m <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      sda_m <= bus.sda;
      sda_r <= sda_m;
    end
  end

  // transfer sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= H_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      step_q <= 3'h0;
      rd_q <= 1'b0;
      rxm_q <= 1'b0;
      lo_q <= 1'b0;
      words_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      hi_q <= 8'h00;
      ack_q <= 1'b1;
      dev_q <= 7'h00;
      idx_q <= 16'h0000;
      wd_q <= 16'h0000;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cmd_ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (cmd_valid) begin
            state_q <= H_START;
            ph_q <= 2'h0;
            step_q <= 3'h0;
            rd_q <= cmd_read;
            rxm_q <= 1'b0;
            lo_q <= 1'b0;
            words_q <= (cmd_words == 8'h00) ? 8'h01 : cmd_words;
            dev_q <= cmd_dev_addr;
            idx_q <= cmd_index;
            wd_q <= cmd_wdata;
            cmd_ready_q <= 1'b0;
            nack_q <= 1'b0;
          end
        end
        H_START: begin
          // also serves as repeated start from clock low
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              default: begin
                scl_q <= 1'b0;
                state_q <= H_BIT;
                bit_q <= 4'h0;
                step_q <= step_q + 3'h1;
                tx_q <= pick(step_q + 3'h1);
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin
                if (bit_q == BYTE_BITS) begin
                  sda_q <= rxm_q ? last_rx : 1'b1;
                end else begin
                  sda_q <= rxm_q ? 1'b1 : tx_q[7];
                end
              end
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bit_q == BYTE_BITS) begin
                  ack_q <= sda_r;
                end else begin
                  rx_q <= {rx_q[6:0], sda_r};
                end
              end
              default: begin
                scl_q <= 1'b0;
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
                if (bit_q == BYTE_BITS) begin
                  bit_q <= 4'h0;
                  if (!rxm_q && ack_q) begin
                    // device refused: end the transfer
                    nack_q <= 1'b1;
                    state_q <= H_STOP;
                  end else if (rxm_q) begin
                    lo_q <= ~lo_q;
                    hi_q <= rx_q;
                    if (lo_q) begin
                      rd_valid_q <= 1'b1;
                      rd_data_q <= {hi_q, rx_q};
                      words_q <= words_q - 8'h01;
                    end
                    if (last_rx) begin
                      state_q <= H_STOP;
                    end
                  end else if (!rd_q && step_q == 3'h5) begin
                    state_q <= H_STOP;
                  end else if (rd_q && step_q == 3'h3) begin
                    // restart skips the data slots: next byte is addr+R
                    state_q <= H_START;
                    step_q  <= 3'h4;
                  end else if (rd_q && step_q == 3'h5) begin
                    rxm_q <= 1'b1;
                  end else begin
                    step_q <= step_q + 3'h1;
                    tx_q <= pick(step_q + 3'h1);
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              default: begin
                state_q <= H_IDLE;
                done_q <= 1'b1;
                cmd_ready_q <= 1'b1;
              end
            endcase
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

endmodule

// file: two_wire_assertions.sv
// concurrent checks on the two-wire bus between host end and device end
`timescale 1ns/1ps
module two_wire_assertions (
  input wire logic clk,          // system clock
  input wire logic reset_n,      // async reset, active low
  input wire logic scl,          // resolved clock wire
  input wire logic sda,          // resolved data wire
  input wire logic host_scl_oe,  // host pulls clock
  input wire logic host_sda_oe,  // host pulls data
  input wire logic dev_sda_o,    // device drive value
  input wire logic dev_sda_oe    // device pulls data
);
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_dev_edge_low: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl) && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
    else $error("device data change not just after clock fall");
  a_dev_pull_low: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data high");
  a_no_fight: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
    else $error("both ends pull data while clock high");
  a_scl_host_only: assert property (scl == !host_scl_oe)
    else $error("clock wire not set by host alone");
  a_start_by_host: assert property (scl && $fell(sda) |-> $rose(host_sda_oe))
    else $error("start not made by host");
  a_stop_by_host: assert property (scl && $rose(sda) |-> $fell(host_sda_oe))
    else $error("stop not made by host");
  a_ack_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device pull too short");
  a_stop_idle: assert property (scl && $rose(sda) |-> (!dev_sda_oe) [*8])
    else $error("device active after stop");
  a_dev_bounded: assert property ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
    else $error("device holds data line too long");
endmodule

// file: testbench.sv
// self-checking bench: host end talks to device end over the bus
`timescale 1ns/1ps
module testbench;
  import two_wire_pkg::*;
  logic        clk, reset_n, addr_sel, soft_reset;  // shared inputs
  logic        cmd_valid, cmd_read, cmd_ready_q;    // host command
  logic [6:0]  cmd_dev_addr;                        // target address
  logic [15:0] cmd_index, cmd_wdata, rd_data_q;     // index and data
  logic [7:0]  cmd_words;                           // read length
  logic        rd_valid_q, done_q, nack_q;          // host results
  logic        wr_strobe_q;                         // device write pulse
  logic [15:0] wr_index_q, wr_data_q;               // device write seen
  int          n_fail, total_checks, n_stb;         // counters
  logic [15:0] mem [0:63];                          // register model
  logic [15:0] rd_q [$];                            // words read back
  logic [31:0] seed;                                // lfsr state
  two_wire_if bus ();
  // short quarter keeps each frame brief
  two_wire_host #(.QTR_CYCLES(8)) two_wire_host_i (.clk(clk),
    .reset_n(reset_n), .bus(bus.host), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr),
    .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_words(cmd_words),
    .cmd_ready_q(cmd_ready_q), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .done_q(done_q), .nack_q(nack_q));
  two_wire_control_slave two_wire_control_slave_i (.clk(clk),
    .reset_n(reset_n), .bus(bus.device), .addr_sel(addr_sel),
    .soft_reset(soft_reset), .wr_strobe_q(wr_strobe_q),
    .wr_index_q(wr_index_q), .wr_data_q(wr_data_q));
  two_wire_assertions two_wire_assertions_i (.clk(clk),
    .reset_n(reset_n), .scl(bus.scl), .sda(bus.sda),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // collect pulses; pre-edge value is the one that stood
  always @(posedge clk) begin
    if (wr_strobe_q === 1'b1) n_stb++;
    if (rd_valid_q === 1'b1) rd_q.push_back(rd_data_q);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // model read: unimplemented places give the default
  function automatic logic [15:0] rmod(input logic [15:0] i);
    return (i < 16'h0040) ? mem[i[5:0]] : REG_DEFAULT;
  endfunction
  task automatic check(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one host command, waited out on done under a bound
  task automatic run(input logic rd, input logic [6:0] a,
                     input logic [15:0] i, w, input logic [7:0] n);
    int k;
    @(negedge clk);
    {cmd_read, cmd_dev_addr, cmd_index, cmd_wdata} = {rd, a, i, w};
    cmd_words = n;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (done_q !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    // a frame that never ends is a failure, not a silent skip
    if (done_q !== 1'b1) n_fail++;
    check("ready", {15'h0000, cmd_ready_q}, 16'h0001);
  endtask
  // write, then compare ack, strobe count and written word
  task automatic wr(input logic [6:0] a, input logic [15:0] i, w,
                    input logic ack);
    int n0;
    n0 = n_stb;
    run(1'b0, a, i, w, 8'h01);
    check("nack", {15'h0000, nack_q}, {15'h0000, !ack});
    check("strobes", 16'(n_stb - n0), {15'h0000, ack});
    if (ack) begin
      check("windex", wr_index_q, i);
      check("wdata", wr_data_q, w);
      if (i < 16'h0040) mem[i[5:0]] = w;
    end
  endtask
  // read n words from index i and compare against the model
  task automatic rdchk(input logic [15:0] i, input int n);
    rd_q.delete();
    run(1'b1, ADDR_BASE, i, 16'h0000, 8'(n));
    check("words", 16'(rd_q.size()), 16'(n));
    for (int j = 0; j < n; j++) begin
      check("rdata", rd_q[j], rmod(16'(i + j)));
    end
  endtask

  // main sequence
  initial begin
    {reset_n, addr_sel, soft_reset, cmd_valid, cmd_read} = 5'h00;
    {cmd_dev_addr, cmd_index, cmd_wdata, cmd_words} = '0;
    foreach (mem[j]) mem[j] = REG_DEFAULT;
    seed = 32'hB04DAA21;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    // random words to first, middle and last but one register
    for (int j = 0; j < 3; j++) begin
      seed = lfsr(seed);
      wr(ADDR_BASE, 16'(j * 31), seed[15:0], 1'b1);
    end
    rdchk(16'h003E, 2);
    rdchk(16'hFFFF, 2);
    wr(7'h1D, 16'h0005, 16'hA5A5, 1'b0);
    // select pin moves the address to its odd twin
    addr_sel = 1'b1;
    seed = lfsr(seed);
    wr(7'h1D, 16'h0007, seed[31:16], 1'b1);
    wr(ADDR_BASE, 16'h0007, 16'h5A5A, 1'b0);
    addr_sel = 1'b0;
    rdchk(16'h0007, 1);
    // software reset clears every register
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    foreach (mem[j]) mem[j] = REG_DEFAULT;
    rdchk(16'h0000, 1);
    give_verdict();
  end
  // watchdog: far beyond the roughly 15k cycles the run needs
  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end
endmodule
